// ===== inc/dod_map.vh
// Constants for the instruction operand decoder: opcode groups, field
// positions and the reserved opcodes that the decoder treats specially.
// Assumes inclusion by bare name from the rtl files.
`ifndef DOD_MAP_VH
`define DOD_MAP_VH

// ****************************************
// Word geometry
// ****************************************
`define DOD_WORD_W        24
`define DOD_OPC_MSB       23
`define DOD_OPC_LSB       16
`define DOD_LONG_W        48

// ****************************************
// Opcode groups, taken from opcode bits 7:5
// ****************************************
`define DOD_GRP_CONTROL   3'h0
`define DOD_GRP_W3        3'h1
`define DOD_GRP_FILE      3'h2
`define DOD_GRP_BIT       3'h3
`define DOD_GRP_LITMOV    3'h4
`define DOD_GRP_LITALU    3'h5
`define DOD_GRP_MAC       3'h6
`define DOD_GRP_DSP       3'h7

// ****************************************
// Categories presented to the datapath
// ****************************************
`define DOD_CAT_WORDBYTE  3'h0
`define DOD_CAT_BIT       3'h1
`define DOD_CAT_LITERAL   3'h2
`define DOD_CAT_DSP       3'h3
`define DOD_CAT_CONTROL   3'h4

// ****************************************
// Reserved opcodes
// ****************************************
`define DOD_OPC_NOP       8'h00
`define DOD_OPC_GOTO2     8'h02
`define DOD_OPC_CALL2     8'h03
`define DOD_OPC_DMOVE2    8'h04
`define DOD_OPC_TABLE_RD  8'h0A
`define DOD_OPC_TABLE_WR  8'h0B

// ****************************************
// Operand field positions
// ****************************************
`define DOD_BASE_MSB      15
`define DOD_BASE_LSB      12
`define DOD_FILE_MSB      12
`define DOD_FDEST_BIT     13
`define DOD_TBLMODE_MSB   15
`define DOD_TBLMODE_LSB   14

`endif

// ===== rtl/dod_classify.v
// Opcode classifier: maps an 8-bit opcode to its category and flags the
// opcodes that occupy two program words. Purely combinational.
// Assumes a registered consumer in the decoder core.
`timescale 1ns/1ps
`include "dod_map.vh"

module dod_classify (
	input  wire [7:0] OPCODE,
	output reg  [2:0] CATEGORY,
	output wire       TWO_WORD,
	output wire       TABLE_OP
);

	// ****************************************
	// Category mapping
	// ****************************************
	// Group bits pick the category; both DSP groups share one
	always @* begin
		case (OPCODE[7:5])
			`DOD_GRP_W3, `DOD_GRP_FILE:     CATEGORY = `DOD_CAT_WORDBYTE;
			`DOD_GRP_BIT:                   CATEGORY = `DOD_CAT_BIT;
			`DOD_GRP_LITMOV, `DOD_GRP_LITALU: CATEGORY = `DOD_CAT_LITERAL;
			`DOD_GRP_MAC, `DOD_GRP_DSP:     CATEGORY = `DOD_CAT_DSP;
			default:                        CATEGORY = `DOD_CAT_CONTROL;
		endcase
	end

	// Exactly three opcodes span two words
	assign TWO_WORD = (OPCODE == `DOD_OPC_GOTO2) || (OPCODE == `DOD_OPC_CALL2) ||
		(OPCODE == `DOD_OPC_DMOVE2);
	assign TABLE_OP = (OPCODE == `DOD_OPC_TABLE_RD) || (OPCODE == `DOD_OPC_TABLE_WR);

endmodule // dod_classify

// ===== rtl/dod_decoder.v
// Instruction operand decoder: splits fetched 24-bit words into opcode
// and operand fields, joins two-word instructions, and presents one
// registered decode per instruction to the execution datapath.
// Assumes the fetch stage is on MCLK and delivers words in program order.
// Function
// - Each single word is 24 bits; top 8 bits form the opcode.
// - Only three opcodes take two words; all others decode from one word.
// - Two-word instructions give 48 bits; lone second word decodes as no-op.
// - Each instruction falls in one of five categories.
// - Three-operand forms give base, second source with mode, destination with mode.
// - File forms give file address and result-to-file or register-zero selector.
// - Bit forms give register or file target, literal or indirect bit position.
// - Literal moves give the literal and its register or file target.
// - Literal arithmetic: base source, literal, separate destination only if different.
// - MAC forms always give accumulator; also multiplier pair, prefetches, write-back.
// - Other DSP forms give accumulator, operand with mode, register or literal shift.
// - Control forms give program address and table access mode.
`timescale 1ns/1ps
`include "dod_map.vh"

module dod_decoder (
	input  wire        MCLK,
	input  wire        RSTN,
	input  wire        INSTR_VALID,
	input  wire [23:0] INSTR_WORD,
	output reg         DEC_VALID,
	output reg  [7:0]  DEC_OPCODE,
	output reg  [2:0]  DEC_CATEGORY,
	output reg         DEC_NOP,
	output reg         DEC_TWO_WORD,
	output reg  [47:0] DEC_LONG_WORD,
	output reg         DEC_BYTE_MODE,
	output reg  [3:0]  BASE_SOURCE_REGISTER,
	output reg  [3:0]  SECOND_SOURCE_REGISTER,
	output reg  [2:0]  SECOND_SOURCE_MODE,
	output reg  [3:0]  DESTINATION_REGISTER,
	output reg  [2:0]  DESTINATION_MODE,
	output reg         DEST_SEPARATE,
	output reg  [12:0] FILE_ADDRESS,
	output reg         DEST_WORKING_REGISTER_ZERO,
	output reg         TARGET_IS_FILE,
	output reg  [3:0]  BIT_POSITION,
	output reg         BIT_INDIRECT,
	output reg  [15:0] LITERAL_VALUE,
	output reg         ACC_SELECT,
	output reg  [3:0]  MUL_REG_FIRST,
	output reg  [3:0]  MUL_REG_SECOND,
	output reg  [1:0]  X_PREFETCH_OP,
	output reg  [1:0]  X_PREFETCH_DEST,
	output reg  [1:0]  Y_PREFETCH_OP,
	output reg  [1:0]  Y_PREFETCH_DEST,
	output reg  [1:0]  ACC_WRITEBACK,
	output reg  [3:0]  SHIFT_AMOUNT_REGISTER,
	output reg  [5:0]  SHIFT_LITERAL,
	output reg         SHIFT_FROM_LITERAL,
	output reg  [22:0] PROGRAM_ADDRESS,
	output reg         TABLE_OP,
	output reg  [1:0]  TABLE_MODE
);

	// ****************************************
	// Helpers
	// ****************************************
	localparam ST_IDLE  = 1'b0;
	localparam ST_WAIT2 = 1'b1;

	// Two-bit short mode widened to the common three-bit mode code
	function [2:0] widen_mode;
		input [1:0] m;
		begin
			widen_mode = {1'b0, m};
		end
	endfunction

	// Multiplier pair code to first and second register, W4..W7 space
	function [7:0] pair_regs;
		input [2:0] p;
		begin
			case (p)
				3'h0:    pair_regs = {4'h4, 4'h5};
				3'h1:    pair_regs = {4'h4, 4'h6};
				3'h2:    pair_regs = {4'h4, 4'h7};
				3'h3:    pair_regs = {4'h5, 4'h6};
				3'h4:    pair_regs = {4'h5, 4'h7};
				3'h5:    pair_regs = {4'h6, 4'h7};
				default: pair_regs = {4'h4, 4'h4};
			endcase
		end
	endfunction

	reg         state;
	reg  [23:0] first_word;
	wire [2:0]  cls_category;
	wire        cls_two_word;
	wire        cls_table;

	// ****************************************
	// Word assembly
	// ****************************************
	// A two-word opcode parks its first word until the second arrives
	wire        is_first  = INSTR_VALID && (state == ST_IDLE) && cls_two_word;
	wire        complete  = INSTR_VALID && !is_first;
	wire [23:0] head      = (state == ST_WAIT2) ? first_word : INSTR_WORD;
	wire [47:0] long_word = {head, INSTR_WORD};
	wire [7:0]  opc       = head[`DOD_OPC_MSB:`DOD_OPC_LSB];
	wire [15:0] op        = head[15:0];

	dod_classify u_classify (
		.OPCODE   (opc),
		.CATEGORY (cls_category),
		.TWO_WORD (cls_two_word),
		.TABLE_OP (cls_table)
	);

	// Sequencer; a lone second word has opcode zero and so never parks
	always @(posedge MCLK) begin
		if (!RSTN) begin
			state      <= ST_IDLE;
			first_word <= 24'h00_0000;
		end else if (is_first) begin
			state      <= ST_WAIT2;
			first_word <= INSTR_WORD;
		end else if (complete) begin
			state      <= ST_IDLE;
		end
	end

	// ****************************************
	// Field extraction
	// ****************************************
	reg [3:0]  next_base;
	reg [3:0]  next_src2;
	reg [2:0]  next_src2_mode;
	reg [3:0]  next_dest;
	reg [2:0]  next_dest_mode;
	reg        next_sep;
	reg [12:0] next_file;
	reg        next_to_zero;
	reg        next_tfile;
	reg [3:0]  next_bitpos;
	reg        next_bitind;
	reg [15:0] next_lit;
	reg        next_acc;
	reg [7:0]  next_pair;
	reg [7:0]  next_pref;
	reg [1:0]  next_awb;
	reg [3:0]  next_shreg;
	reg [5:0]  next_shlit;
	reg        next_shsel;
	reg [22:0] next_paddr;
	reg [1:0]  next_tmode;

	// Every field but the base source defaults to zero so unused ones read as no-op values
	always @* begin
		next_base      = op[`DOD_BASE_MSB:`DOD_BASE_LSB];
		next_src2      = 4'h0;
		next_src2_mode = 3'h0;
		next_dest      = 4'h0;
		next_dest_mode = 3'h0;
		next_sep       = 1'b0;
		next_file      = 13'h0000;
		next_to_zero   = 1'b0;
		next_tfile   = 1'b0;
		next_bitpos  = 4'h0;
		next_bitind  = 1'b0;
		next_lit     = 16'h0000;
		next_acc     = 1'b0;
		next_pair    = 8'h00;
		next_pref    = 8'h00;
		next_awb     = 2'h0;
		next_shreg   = 4'h0;
		next_shlit   = 6'h00;
		next_shsel   = 1'b0;
		next_paddr   = 23'h00_0000;
		next_tmode   = 2'h0;
		case (opc[7:5])
			`DOD_GRP_W3: begin
				next_dest      = op[11:8];
				next_dest_mode = widen_mode(op[7:6]);
				next_src2      = op[5:2];
				next_src2_mode = widen_mode(op[1:0]);
				next_sep     = 1'b1;
			end
			`DOD_GRP_FILE: begin
				next_file  = op[`DOD_FILE_MSB:0];
				next_to_zero = !op[`DOD_FDEST_BIT];
			end
			`DOD_GRP_BIT: begin
				// Opcode bit 0 picks file target, bit 1 indirect position
				next_tfile  = opc[0];
				next_bitind = opc[1];
				next_bitpos = opc[1] ? 4'h0 : op[15:12];
				next_file   = opc[0] ? {1'b0, op[11:0]} : 13'h0000;
				next_src2      = opc[0] ? 4'h0 : op[3:0];
				next_src2_mode = opc[0] ? 3'h0 : op[6:4];
			end
			`DOD_GRP_LITMOV: begin
				// The third two-word opcode lives in control; here single-word only
				next_tfile = opc[0];
				next_lit   = opc[0] ? {8'h00, op[15:8]} : {4'h0, op[15:4]};
				next_base  = opc[0] ? 4'h0 : op[3:0];
				next_file  = opc[0] ? {5'h00, op[7:0]} : 13'h0000;
			end
			`DOD_GRP_LITALU: begin
				next_lit = {11'h000, op[11:7]};
				next_sep = op[6];
				// Destination defaults to the first source when not separate
				next_dest      = op[6] ? op[5:2] : op[15:12];
				next_dest_mode = op[6] ? widen_mode(op[1:0]) : 3'h0;
			end
			`DOD_GRP_MAC: begin
				next_base = 4'h0;
				next_acc  = op[15];
				next_pair = pair_regs(op[14:12]);
				next_pref = op[11:4];
				next_awb  = opc[1:0];
			end
			`DOD_GRP_DSP: begin
				next_base      = 4'h0;
				next_acc       = op[15];
				next_shsel     = op[14];
				next_shlit     = op[14] ? op[13:8] : 6'h00;
				next_shreg     = op[14] ? 4'h0 : op[11:8];
				next_src2      = op[3:0];
				next_src2_mode = op[6:4];
			end
			default: begin
				next_base = 4'h0;
				// Two-word address forms join both halves, bit 0 forced low
				if (opc == `DOD_OPC_GOTO2 || opc == `DOD_OPC_CALL2)
					next_paddr = {long_word[6:0], op[15:1], 1'b0};
				else if (opc == `DOD_OPC_DMOVE2) begin
					next_lit  = long_word[15:0];
					next_file = op[12:0];
				end else if (cls_table)
					next_tmode = op[`DOD_TBLMODE_MSB:`DOD_TBLMODE_LSB];
				else if (opc != `DOD_OPC_NOP)
					next_paddr = {7'h00, op};
			end
		endcase
	end

	// ****************************************
	// Output register
	// ****************************************
	// All fields load together with the opcode; reset leaves a no-op
	always @(posedge MCLK) begin
		if (!RSTN) begin
			DEC_VALID                  <= 1'b0;
			DEC_OPCODE                 <= `DOD_OPC_NOP;
			DEC_CATEGORY               <= `DOD_CAT_CONTROL;
			DEC_NOP                    <= 1'b1;
			DEC_TWO_WORD               <= 1'b0;
			DEC_LONG_WORD              <= 48'h0000_0000_0000;
			DEC_BYTE_MODE              <= 1'b0;
			BASE_SOURCE_REGISTER       <= 4'h0;
			SECOND_SOURCE_REGISTER     <= 4'h0;
			SECOND_SOURCE_MODE         <= 3'h0;
			DESTINATION_REGISTER       <= 4'h0;
			DESTINATION_MODE           <= 3'h0;
			DEST_SEPARATE              <= 1'b0;
			FILE_ADDRESS               <= 13'h0000;
			DEST_WORKING_REGISTER_ZERO <= 1'b0;
			TARGET_IS_FILE             <= 1'b0;
			BIT_POSITION               <= 4'h0;
			BIT_INDIRECT               <= 1'b0;
			LITERAL_VALUE              <= 16'h0000;
			ACC_SELECT                 <= 1'b0;
			MUL_REG_FIRST              <= 4'h0;
			MUL_REG_SECOND             <= 4'h0;
			{X_PREFETCH_OP, X_PREFETCH_DEST} <= 4'h0;
			{Y_PREFETCH_OP, Y_PREFETCH_DEST} <= 4'h0;
			ACC_WRITEBACK              <= 2'h0;
			SHIFT_AMOUNT_REGISTER      <= 4'h0;
			SHIFT_LITERAL              <= 6'h00;
			SHIFT_FROM_LITERAL         <= 1'b0;
			PROGRAM_ADDRESS            <= 23'h00_0000;
			TABLE_OP                   <= 1'b0;
			TABLE_MODE                 <= 2'h0;
		end else begin
			DEC_VALID <= complete;
			if (complete) begin
				DEC_OPCODE                 <= opc;
				DEC_CATEGORY               <= cls_category;
				DEC_NOP                    <= (opc == `DOD_OPC_NOP);
				DEC_TWO_WORD               <= (state == ST_WAIT2);
				DEC_LONG_WORD              <= (state == ST_WAIT2) ? long_word :
					{24'h00_0000, INSTR_WORD};
				DEC_BYTE_MODE              <= (opc[7:5] == `DOD_GRP_W3 ||
					opc[7:5] == `DOD_GRP_FILE) ? opc[0] : 1'b0;
				BASE_SOURCE_REGISTER       <= next_base;
				SECOND_SOURCE_REGISTER     <= next_src2;
				SECOND_SOURCE_MODE         <= next_src2_mode;
				DESTINATION_REGISTER       <= next_dest;
				DESTINATION_MODE           <= next_dest_mode;
				DEST_SEPARATE              <= next_sep;
				FILE_ADDRESS               <= next_file;
				DEST_WORKING_REGISTER_ZERO <= next_to_zero;
				TARGET_IS_FILE             <= next_tfile;
				BIT_POSITION               <= next_bitpos;
				BIT_INDIRECT               <= next_bitind;
				LITERAL_VALUE              <= next_lit;
				ACC_SELECT                 <= next_acc;
				MUL_REG_FIRST              <= next_pair[7:4];
				MUL_REG_SECOND             <= next_pair[3:0];
				{X_PREFETCH_OP, X_PREFETCH_DEST} <= next_pref[7:4];
				{Y_PREFETCH_OP, Y_PREFETCH_DEST} <= next_pref[3:0];
				ACC_WRITEBACK              <= next_awb;
				SHIFT_AMOUNT_REGISTER      <= next_shreg;
				SHIFT_LITERAL              <= next_shlit;
				SHIFT_FROM_LITERAL         <= next_shsel;
				PROGRAM_ADDRESS            <= next_paddr;
				TABLE_OP                   <= cls_table;
				TABLE_MODE                 <= next_tmode;
			end
		end
	end

endmodule // dod_decoder

// ===== dv/dod_monitor.sv
// Checker: answer timing, word pairing and flag relations of the decoder.
// Assumes it is bound to dod_decoder and sees only its ports.
`timescale 1ns/1ps
module dod_monitor (
	input wire        MCLK,
	input wire        RSTN,
	input wire        INSTR_VALID,
	input wire [23:0] INSTR_WORD,
	input wire        DEC_VALID,
	input wire [7:0]  DEC_OPCODE,
	input wire [2:0]  DEC_CATEGORY,
	input wire        DEC_NOP,
	input wire        DEC_TWO_WORD,
	input wire [47:0] DEC_LONG_WORD,
	input wire        DEC_BYTE_MODE,
	input wire        TABLE_OP,
	input wire [1:0]  TABLE_MODE
);
	// ******************
	// Helper state
	// ******************
	reg        pend;
	wire       lng = INSTR_WORD[23:16] inside {8'h02, 8'h03, 8'h04};
	wire [2:0] grp = DEC_OPCODE[7:5];
	wire [2:0] cat = (grp == 3'h0) ? 3'h4 : (grp < 3'h3) ? 3'h0 : (grp == 3'h3) ? 3'h1 :
		(grp < 3'h6) ? 3'h2 : 3'h3;
	// Parked first word; reset drops it just as the sequencer must
	always @(posedge MCLK) begin
		if (!RSTN)
			pend <= 1'b0;
		else if (INSTR_VALID)
			pend <= !pend && lng;
	end
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RSTN);
	a_single_answer: assert property (INSTR_VALID && !pend && !lng |=> DEC_VALID &&
		DEC_LONG_WORD == {24'h0, $past(INSTR_WORD)}) else $error("single word answer");
	a_first_silent: assert property (INSTR_VALID && !pend && lng |=> !DEC_VALID)
		else $error("answer after first half");
	a_pair_join: assert property (INSTR_VALID && pend |=> DEC_VALID && DEC_TWO_WORD &&
		DEC_LONG_WORD[23:0] == $past(INSTR_WORD)) else $error("pair not joined");
	a_hold_fields: assert property (!DEC_VALID && $past(RSTN) |-> $stable(DEC_LONG_WORD) &&
		$stable(DEC_CATEGORY)) else $error("fields moved without answer");
	a_nop_flag: assert property (DEC_VALID |-> DEC_NOP == (DEC_OPCODE == 8'h00))
		else $error("no-op flag wrong");
	a_category_map: assert property (DEC_VALID |-> DEC_CATEGORY == cat)
		else $error("category wrong");
	a_byte_mode: assert property (DEC_VALID |-> DEC_BYTE_MODE ==
		((grp == 3'h1 || grp == 3'h2) && DEC_OPCODE[0])) else $error("byte mode wrong");
	a_table_mode: assert property (DEC_VALID && DEC_OPCODE[7:1] == 7'h05 |-> TABLE_OP &&
		TABLE_MODE == DEC_LONG_WORD[15:14]) else $error("table mode wrong");
	a_reset_state: assert property (disable iff (1'b0) !RSTN |=> !DEC_VALID && DEC_NOP &&
		DEC_CATEGORY == 3'h4) else $error("reset state wrong");
endmodule // dod_monitor

// ===== dv/dod_fetch_model.sv
// Fetch stage model: offers words to the decoder on falling clock edges.
// Assumes the bench calls its tasks in program order.
`timescale 1ns/1ps
module dod_fetch_model (
	input  wire        MCLK,
	output reg         VALID,
	output reg  [23:0] WORD
);
	initial begin
		VALID = 1'b0;
		WORD  = 24'h0;
	end
	// Idle cycles flip the word so stale data never looks valid
	task automatic rest(input integer n);
		repeat (n) begin
			@(negedge MCLK);
			VALID <= 1'b0;
			WORD  <= ~WORD;
		end
	endtask
	// One word for one cycle, then a gap
	task automatic offer(input [23:0] w, input integer gap);
		@(negedge MCLK);
		VALID <= 1'b1;
		WORD  <= w;
		rest(gap);
	endtask
endmodule // dod_fetch_model

// ===== dv/dod_decoder_tb.sv
// Bench: reset, opcode sweep, random stream and mid-run reset, scoreboarded.
// Assumes the decoder, the fetch model and the checker are compiled first.
`timescale 1ns/1ps
`define CHK(a, b) begin \
	checks_done++; \
	if ((a) !== (b)) begin \
		n_fail++; \
		$display("mismatch at %0t: got %h want %h", $time, (a), (b)); \
	end \
end
module dod_decoder_tb;
	reg          mclk;
	reg          rstn;
	wire         iv;
	wire [23:0]  iw;
	integer      n_fail = 0;
	integer      checks_done = 0;
	integer      cyc = 0;
	integer      i;
	reg  [100:0] exq[$];
	reg  [100:0] got;
	reg  [100:0] want;
	reg          pend = 1'b0;
	reg  [23:0]  first;
	localparam [47:0] PAIRS = 48'h6757_5647_4645;
	dod_fetch_model u_fetch (.MCLK(mclk), .VALID(iv), .WORD(iw));
	dod_decoder u_dut (.MCLK(mclk), .RSTN(rstn), .INSTR_VALID(iv), .INSTR_WORD(iw),
		.DEC_VALID(), .DEC_OPCODE(), .DEC_CATEGORY(), .DEC_NOP(), .DEC_TWO_WORD(),
		.DEC_LONG_WORD(), .DEC_BYTE_MODE(), .BASE_SOURCE_REGISTER(),
		.SECOND_SOURCE_REGISTER(), .SECOND_SOURCE_MODE(), .DESTINATION_REGISTER(),
		.DESTINATION_MODE(), .DEST_SEPARATE(), .FILE_ADDRESS(), .TARGET_IS_FILE(),
		.DEST_WORKING_REGISTER_ZERO(), .BIT_POSITION(), .BIT_INDIRECT(), .LITERAL_VALUE(),
		.ACC_SELECT(), .MUL_REG_FIRST(), .MUL_REG_SECOND(), .X_PREFETCH_OP(),
		.X_PREFETCH_DEST(), .Y_PREFETCH_OP(), .Y_PREFETCH_DEST(), .ACC_WRITEBACK(),
		.SHIFT_AMOUNT_REGISTER(), .SHIFT_LITERAL(), .SHIFT_FROM_LITERAL(),
		.PROGRAM_ADDRESS(), .TABLE_OP(), .TABLE_MODE());
	// *******************
	// Expected and observed operand keys
	// *******************
	function automatic [39:0] ekey(input [23:0] a, input [23:0] b);
		reg [7:0]  c;
		reg [15:0] o;
		reg [3:0]  bs;
		c = a[23:16];
		o = a[15:0];
		bs = o[15:12];
		case (c[7:5])
		3'h1: ekey = {bs, o[5:2], 1'b0, o[1:0], o[11:8], 1'b0, o[7:6], 1'b1};
		3'h2: ekey = {bs, o[12:0], !o[13]};
		3'h3: ekey = {bs, c[0], c[1], c[1] ? 4'h0 : o[15:12],
			c[0] ? {1'b0, o[11:0], 7'h0} : {13'h0, o[3:0], o[6:4]}};
		3'h4: ekey = c[0] ? {12'h0, o[15:8], 5'h0, o[7:0]} : {o[3:0], 4'h0, o[15:4], 13'h0};
		3'h5: ekey = {bs, 11'h0, o[11:7], o[6] ? {o[5:2], 1'b0, o[1:0]} : {bs, 3'h0}, o[6]};
		3'h6: ekey = {o[15], o[14:12] > 3'h5 ? 8'h44 : PAIRS[o[14:12]*8 +: 8], o[11:4], c[1:0]};
		3'h7: ekey = {o[15], o[14], o[14] ? o[13:8] : 6'h0, o[14] ? 4'h0 : o[11:8], o[3:0],
			o[6:4]};
		default: ekey = (c == 8'h04) ? {b[15:0], o[12:0]} : (c == 8'h02 || c == 8'h03) ?
			{b[6:0], o[15:1], 4'h0} : (c[7:1] == 7'h05) ? {23'h0, 1'b1, o[15:14]} :
			{7'h0, (c == 8'h00) ? 16'h0 : o, 3'h0};
		endcase
	endfunction
	function automatic [39:0] okey(input [7:0] c);
		case (c[7:5])
		3'h1: okey = {u_dut.BASE_SOURCE_REGISTER, u_dut.SECOND_SOURCE_REGISTER,
			u_dut.SECOND_SOURCE_MODE, u_dut.DESTINATION_REGISTER, u_dut.DESTINATION_MODE,
			u_dut.DEST_SEPARATE};
		3'h2: okey = {u_dut.BASE_SOURCE_REGISTER, u_dut.FILE_ADDRESS,
			u_dut.DEST_WORKING_REGISTER_ZERO};
		3'h3: okey = {u_dut.BASE_SOURCE_REGISTER, u_dut.TARGET_IS_FILE, u_dut.BIT_INDIRECT,
			u_dut.BIT_POSITION, u_dut.FILE_ADDRESS, u_dut.SECOND_SOURCE_REGISTER,
			u_dut.SECOND_SOURCE_MODE};
		3'h4: okey = {u_dut.BASE_SOURCE_REGISTER, u_dut.LITERAL_VALUE, u_dut.FILE_ADDRESS};
		3'h5: okey = {u_dut.BASE_SOURCE_REGISTER, u_dut.LITERAL_VALUE,
			u_dut.DESTINATION_REGISTER, u_dut.DESTINATION_MODE, u_dut.DEST_SEPARATE};
		3'h6: okey = {u_dut.ACC_SELECT, u_dut.MUL_REG_FIRST, u_dut.MUL_REG_SECOND,
			u_dut.X_PREFETCH_OP, u_dut.X_PREFETCH_DEST, u_dut.Y_PREFETCH_OP,
			u_dut.Y_PREFETCH_DEST, u_dut.ACC_WRITEBACK};
		3'h7: okey = {u_dut.ACC_SELECT, u_dut.SHIFT_FROM_LITERAL, u_dut.SHIFT_LITERAL,
			u_dut.SHIFT_AMOUNT_REGISTER, u_dut.SECOND_SOURCE_REGISTER, u_dut.SECOND_SOURCE_MODE};
		default: okey = (c == 8'h04) ? {u_dut.LITERAL_VALUE, u_dut.FILE_ADDRESS} :
			{u_dut.PROGRAM_ADDRESS, u_dut.TABLE_OP, u_dut.TABLE_MODE};
		endcase
	endfunction
	// Offer a word; the note is made when an instruction is complete
	task automatic put(input [23:0] x, input integer gap);
		reg [2:0] g;
		reg       l;
		g = x[23:21];
		l = x[23:16] inside {8'h02, 8'h03, 8'h04};
		if (pend)
			exq.push_back({first[23:16], 3'h4, 2'b10, first, x, ekey(first, x)});
		else if (l)
			first = x;
		else
			exq.push_back({x[23:16], (g == 3'h0) ? 3'h4 : (g < 3'h3) ? 3'h0 : (g == 3'h3) ?
				3'h1 : (g < 3'h6) ? 3'h2 : 3'h3, 1'b0, x[23:16] == 8'h00, 24'h0, x, ekey(x, 24'h0)});
		pend = !pend && l;
		u_fetch.offer(x, gap);
	endtask
	task automatic summarize();
		if (exq.size() != 0)
			n_fail++;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Clock, and a cycle ceiling well above the expected run
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 4000) begin
			n_fail++;
			summarize();
		end
	end
	// Scoreboard: every answer takes the oldest note
	always @(negedge mclk) begin
		if (u_dut.DEC_VALID === 1'b1) begin
			got = {u_dut.DEC_OPCODE, u_dut.DEC_CATEGORY, u_dut.DEC_TWO_WORD, u_dut.DEC_NOP,
				u_dut.DEC_LONG_WORD, okey(u_dut.DEC_OPCODE)};
			if (exq.size() == 0)
				`CHK(got, 101'h0)
			else begin
				// Pop once; the compare macro evaluates its arguments twice
				want = exq.pop_front();
				`CHK(got, want)
			end
		end
	end
	// Main sequence
	initial begin
		rstn = 1'b0;
		void'($urandom(32'h411d));
		repeat (12) @(negedge mclk);
		rstn <= 1'b1;
		`CHK({u_dut.DEC_VALID, u_dut.DEC_NOP, u_dut.DEC_CATEGORY}, 5'b0_1100)
		$display("test reset done");
		// Every opcode, random then all-ones operands, gaps 0..2
		for (i = 0; i < 512; i++) begin
			put({i[7:0], i[8] ? 16'hffff : 16'($urandom)}, i % 3);
			if (pend)
				put({8'h00, 16'($urandom)}, 0);
		end
		$display("test sweep done");
		// Random words: second halves with any top byte, lone no-op words
		for (i = 0; i < 300; i++)
			put(24'($urandom), $urandom % 3);
		put(24'h00_5a5a, 0);
		put(24'h00_a5a5, 1);
		$display("test random done");
		// Reset with a first half parked, then a plain word
		put(24'h02_1357, 0);
		u_fetch.rest(1);
		rstn <= 1'b0;
		repeat (2) @(negedge mclk);
		rstn <= 1'b1;
		pend = 1'b0;
		`CHK({u_dut.DEC_VALID, u_dut.DEC_NOP, u_dut.DEC_CATEGORY, u_dut.DEC_LONG_WORD}, {5'b0_1100, 48'h0000_0000_0000})
		put(24'h20_1357, 0);
		put(24'h03_0000, 0);
		put(24'hff_ffff, 2);
		$display("test midreset done");
		summarize();
	end
endmodule // dod_decoder_tb
bind dod_decoder dod_monitor u_mon (.MCLK(MCLK), .RSTN(RSTN), .INSTR_VALID(INSTR_VALID),
	.INSTR_WORD(INSTR_WORD), .DEC_VALID(DEC_VALID), .DEC_OPCODE(DEC_OPCODE),
	.DEC_CATEGORY(DEC_CATEGORY), .DEC_NOP(DEC_NOP), .DEC_TWO_WORD(DEC_TWO_WORD),
	.DEC_LONG_WORD(DEC_LONG_WORD), .DEC_BYTE_MODE(DEC_BYTE_MODE), .TABLE_OP(TABLE_OP),
	.TABLE_MODE(TABLE_MODE));
